// ---- shared/wpc_pkg.sv ----
// package for the write protect controller: offsets, fields, resets
package wpc_pkg;
    // register byte addresses
    localparam logic [7:0] WPC_OFF_STATUS  = 8'h00;
    localparam logic [7:0] WPC_OFF_COMMAND = 8'h04;
    localparam logic [7:0] WPC_OFF_IRQ_ST  = 8'h08;
    localparam logic [7:0] WPC_OFF_IRQ_MSK = 8'h0c;
    localparam logic [7:0] WPC_OFF_ACK     = 8'h10;
    localparam logic [7:0] WPC_OFF_PATTERN = 8'h14;
    // status byte fields
    localparam int WPC_ST_BLOCK   = 1;
    localparam int WPC_ST_PROT_ON = 2;
    localparam int WPC_ST_FLAG    = 3;
    localparam int WPC_ST_EXAM    = 5;
    // command byte fields
    localparam int WPC_CMD_INTERRUPT_DISALLOW_CMD = 0;
    localparam int WPC_CMD_ARM    = 1;
    localparam int WPC_CMD_P_ON   = 2;
    localparam int WPC_CMD_P_OFF  = 3;
    localparam int WPC_CMD_LOWER  = 4;
    localparam int WPC_CMD_UPPER  = 5;
    // interrupt status fields
    localparam int WPC_IRQ_FLAG   = 0;
    // reset values and response codes
    localparam logic [31:0] WPC_PATTERN_RST = 32'h0000_0000;
    localparam logic [1:0]  WPC_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  WPC_RESP_SLVERR = 2'h2;
    // memory layout: 128KB in 32 pages of 4KB, one pattern bit per page
    localparam int WPC_MEM_AW     = 17;
    localparam int WPC_PAGE_SHIFT = 12;
endpackage : wpc_pkg

// ---- shared/wpc_wr_if.sv ----
// memory write path carrier between the controller and its guard
`timescale 1ns/1ps
interface wpc_wr_if;
    logic        prot_on;
    logic [31:0] pattern;
    logic        wr_req;
    logic [16:0] wr_addr;
    logic        blocked;
    modport ctrl  (output prot_on, output pattern, output wr_req, output wr_addr,
                   input blocked);
    modport guard (input prot_on, input pattern, input wr_req, input wr_addr,
                   output blocked);
endinterface : wpc_wr_if

// ---- sim/tb_write_protect_control.sv ----
// testbench for the write protect controller
`timescale 1ns/1ps
module tb_write_protect_control;
    import wpc_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, mem_wr_req, mem_wr_en, processor_init_control;
    logic        upper_block_select, irq, go, clr;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, page_hit, rd_d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [16:0] mem_wr_addr, mem_wr_addr_out, go_addr;
    int          error_cnt = 0;
    int          n_tests = 0;

    wpc_top wpc_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_wr_req, .mem_wr_addr, .mem_wr_en,
        .mem_wr_addr_out, .processor_init_control, .upper_block_select, .irq);
    wpc_mem_proc wpc_mem_proc_i (.aclk, .go, .go_addr, .clr, .mem_wr_req, .mem_wr_addr,
        .mem_wr_en, .mem_wr_addr_out, .page_hit);

    // 20 MHz clock
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_done, w_done;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw_done = 1'b0;
        w_done = 1'b0;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (!s_axi_bvalid) @(posedge aclk);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge aclk);
        rd_d = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic st(input logic [7:0] e);
        rd(WPC_OFF_STATUS);
        chk(rd_d[7:0], e);
    endtask

    // one write attempt; the page record is cleared first, then flag and irq settle
    task automatic hit(input logic [16:0] a);
        @(posedge aclk);
        go <= 1'b1;
        clr <= 1'b1;
        go_addr <= a;
        @(posedge aclk);
        go <= 1'b0;
        clr <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask

    task automatic t_block;
        st(8'h00);
        rd(8'h18);
        chk({6'h0, rsp}, {6'h0, WPC_RESP_SLVERR});
        wr(WPC_OFF_COMMAND, 32'h20);
        chk({6'h0, rsp}, {6'h0, WPC_RESP_OKAY});
        st(8'h02);
        // an unmapped write must be refused and leave the switch alone
        wr(8'h18, 32'h10);
        chk({6'h0, rsp}, {6'h0, WPC_RESP_SLVERR});
        st(8'h02);
        chk({7'h0, upper_block_select}, 8'h01);
        wr(WPC_OFF_COMMAND, 32'h10);
        st(8'h00);
        chk({7'h0, upper_block_select}, 8'h00);
        $display("block switch test done");
    endtask

    task automatic t_prot;
        wr(WPC_OFF_PATTERN, 32'h8);
        rd(WPC_OFF_PATTERN);
        chk(rd_d[7:0], 8'h08);
        wr(WPC_OFF_IRQ_MSK, 32'h1);
        rd(WPC_OFF_IRQ_MSK);
        chk(rd_d[7:0], 8'h01);
        wr(WPC_OFF_COMMAND, 32'h06);
        st(8'h04);
        hit(17'h03000);
        chk(page_hit[7:0], 8'h00);
        st(8'h2c);
        chk({7'h0, irq}, 8'h01);
        rd(WPC_OFF_IRQ_ST);
        chk(rd_d[7:0], 8'h01);
        hit(17'h04000);
        chk(page_hit[7:0], 8'h10);
        st(8'h2c);
        wr(WPC_OFF_ACK, 32'h0);
        st(8'h04);
        chk({7'h0, irq}, 8'h00);
        hit(17'h03fff);
        wr(WPC_OFF_IRQ_ST, 32'h1);
        st(8'h2c);
        chk({7'h0, irq}, 8'h00);
        wr(WPC_OFF_COMMAND, 32'h01);
        st(8'h04);
        hit(17'h03000);
        st(8'h2c);
        chk({7'h0, irq}, 8'h00);
        wr(WPC_OFF_COMMAND, 32'h08);
        st(8'h00);
        hit(17'h03000);
        chk(page_hit[7:0], 8'h08);
        $display("protection test done");
    endtask

    task automatic t_init;
        wr(WPC_OFF_PATTERN, 32'hffffffff);
        wr(WPC_OFF_COMMAND, 32'h26);
        hit(17'h00000);
        st(8'h2e);
        processor_init_control <= 1'b1;
        repeat (6) @(posedge aclk);
        go <= 1'b1;
        go_addr <= 17'h00000;
        repeat (4) @(posedge aclk);
        go <= 1'b0;
        processor_init_control <= 1'b0;
        repeat (4) @(posedge aclk);
        chk(page_hit[7:0], 8'h01);
        st(8'h00);
        chk({6'h0, upper_block_select, irq}, 8'h00);
        $display("init test done");
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // all inputs defined at time zero, reset held for 16 cycles
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
        {s_axi_rready, processor_init_control, go, clr} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, go_addr} = 65'h0;
        s_axi_wstrb = 4'hf;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_block;
        t_prot;
        t_init;
        report_and_stop;
    end

    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        $display("unexpected at %0t: watchdog expired", $time);
        report_and_stop;
    end
endmodule // tb_write_protect_control

// ---- sim/wpc_mem_proc.sv ----
// processor write path model: issues memory writes and records pages written
`timescale 1ns/1ps
module wpc_mem_proc (
    // bench commands
    input wire logic        aclk,
    input wire logic        go,
    input wire logic [16:0] go_addr,
    input wire logic        clr,
    // controller side
    output logic            mem_wr_req,
    output logic [16:0]     mem_wr_addr,
    input wire logic        mem_wr_en,
    input wire logic [16:0] mem_wr_addr_out,
    // pages that really took a write
    output logic [31:0]     page_hit
);
    initial begin
        mem_wr_req = 1'b0;
        mem_wr_addr = 17'h00000;
        page_hit = 32'h00000000;
    end
    // idle address inverts, so a stale value never looks like a live one
    always @(posedge aclk) begin
        mem_wr_req <= go;
        mem_wr_addr <= go ? go_addr : ~mem_wr_addr;
        if (clr) begin
            page_hit <= 32'h00000000;
        end else if (mem_wr_en) begin
            page_hit[mem_wr_addr_out[16:12]] <= 1'b1;
        end
    end
endmodule // wpc_mem_proc

// ---- sim/wpc_top_sva.sv ----
// checker for the write protect controller, bound to its top ports
`timescale 1ns/1ps
module wpc_top_sva
    import wpc_pkg::*;
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    // memory path
    input wire logic        mem_wr_req,
    input wire logic [16:0] mem_wr_addr,
    input wire logic        mem_wr_en,
    input wire logic [16:0] mem_wr_addr_out,
    // control and outputs
    input wire logic        processor_init_control,
    input wire logic        upper_block_select,
    input wire logic        irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic       cmd_r;
    logic [7:0] wd_r;
    logic [4:0] init_r;
    // last write target and low byte; a cleared lane 0 means no effect
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) begin
            cmd_r <= (s_axi_awaddr == WPC_OFF_COMMAND);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wd_r <= s_axi_wdata[7:0] & {8{s_axi_wstrb[0]}};
        end
    end
    // init history, since the pin crosses a synchroniser first
    always_ff @(posedge aclk) begin
        init_r <= {init_r[3:0], processor_init_control};
    end
    AST_WEN_CAUSE: assert property (
        mem_wr_en |-> $past(mem_wr_req))
        else $error("write enable without a request");
    AST_ADDR_DLY: assert property (
        $past(mem_wr_req) |-> mem_wr_addr_out == $past(mem_wr_addr))
        else $error("write address not passed on");
    // the switch output is one register behind the write effect, so the
    // response was high in the cycle before the output moves
    AST_BLK_RISE: assert property (
        $rose(upper_block_select) |-> $past(s_axi_bvalid))
        else $error("block switch set without a write");
    AST_BLK_FALL: assert property (
        $fell(upper_block_select) |-> $past(s_axi_bvalid) || |init_r)
        else $error("block switch cleared without cause");
    AST_BLK_SET: assert property (
        $rose(s_axi_bvalid) && cmd_r && wd_r[5] && !wd_r[4] |=> upper_block_select)
        else $error("upper block command ignored");
    AST_BLK_CLR: assert property (
        $rose(s_axi_bvalid) && cmd_r && wd_r[4] |=> !upper_block_select)
        else $error("lower block command ignored");
    AST_INTERRUPT_DISALLOW_CMD: assert property (
        $rose(s_axi_bvalid) && cmd_r && wd_r[0] |=> !irq)
        else $error("irq still high after interrupt_disallow_cmd");
    AST_IRQ_RISE: assert property (
        $rose(irq) |-> $past(mem_wr_req, 2) || $past(s_axi_bvalid))
        else $error("irq rose without cause");
    AST_INIT: assert property (
        processor_init_control [*6] |-> !upper_block_select && !irq)
        else $error("init did not clear state");
    AST_OPEN: assert property (
        processor_init_control [*6] ##0 mem_wr_req |=> mem_wr_en)
        else $error("write blocked with protection off");
endmodule // wpc_top_sva

bind wpc_top wpc_top_sva wpc_top_sva_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .mem_wr_req, .mem_wr_addr, .mem_wr_en, .mem_wr_addr_out, .processor_init_control,
    .upper_block_select, .irq);

// ---- src/wpc_guard.sv ----
// write guard: decides if a memory write hits a protected page
`timescale 1ns/1ps
module wpc_guard
    import wpc_pkg::*;
(
    // write path
    wpc_wr_if.guard wr
);
    logic [4:0] page;

    // page index from the top address bits
    assign page = wr.wr_addr[WPC_MEM_AW-1:WPC_PAGE_SHIFT];
    // blocking is combinational so the write is stopped in the same cycle
    assign wr.blocked = wr.wr_req & wr.prot_on & wr.pattern[page];
endmodule : wpc_guard

// ---- src/wpc_top.sv ----
// write protect controller: axi4-lite registers, protection and block switch
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module wpc_top
    import wpc_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // memory write path
    input  wire logic        mem_wr_req,
    input  wire logic [16:0] mem_wr_addr,
    output logic             mem_wr_en,
    output logic [16:0]      mem_wr_addr_out,
    // processor processor_init_control control, an asynchronous pin
    input  wire logic        processor_init_control,
    // block switch and interrupt
    output logic             upper_block_select,
    output logic             irq
);
    // write channel holding state
    logic        aw_held_r;
    logic [7:0]  aw_addr_r;
    logic        w_held_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        wr_fire;
    // read channel
    logic        rd_fire;
    // control state
    logic        prot_on_r;
    logic        armed_r;
    logic        protected_write_flag_r;
    logic        irq_st_r;
    logic        irq_msk_r;
    logic [31:0] pattern_r;
    logic        upper_r;
    // init synchroniser
    logic        init_s1_r;
    logic        init_s2_r;
    // decoded writes
    logic        cmd_wr;
    logic        ack_wr;
    logic        stclr_wr;
    logic        msk_wr;
    logic        pat_wr;
    logic        pwf_clear;
    logic        prot_hit;
    logic [7:0]  status_byte;
    logic [7:0]  cmd_byte;

    wpc_wr_if wr ();

    wpc_guard u_guard (
        .wr (wr)
    );

    // address decode shared by reads and writes
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == WPC_OFF_STATUS) || (a == WPC_OFF_COMMAND) ||
                      (a == WPC_OFF_IRQ_ST) || (a == WPC_OFF_IRQ_MSK) ||
                      (a == WPC_OFF_ACK) || (a == WPC_OFF_PATTERN);
    endfunction

    // init pin passes two flops before any logic sees it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            init_s1_r <= 1'b0;
            init_s2_r <= 1'b0;
        end else begin
            init_s1_r <= processor_init_control;
            init_s2_r <= init_s1_r;
        end
    end

    // write address and data are taken independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end
    end

    // ready lines are registered and drop once a beat is held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    // a write executes once both halves are held and no response is pending
    assign wr_fire  = aw_held_r && w_held_r && !s_axi_bvalid;
    assign cmd_byte = w_data_r[7:0];
    assign cmd_wr   = wr_fire && (aw_addr_r == WPC_OFF_COMMAND) && w_strb_r[0];
    assign ack_wr   = wr_fire && (aw_addr_r == WPC_OFF_ACK) && w_strb_r[0];
    assign stclr_wr = wr_fire && (aw_addr_r == WPC_OFF_IRQ_ST) && w_strb_r[0];
    assign msk_wr   = wr_fire && (aw_addr_r == WPC_OFF_IRQ_MSK) && w_strb_r[0];
    assign pat_wr   = wr_fire && (aw_addr_r == WPC_OFF_PATTERN);

    // write response, slverr for unmapped addresses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= WPC_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_mapped(aw_addr_r) ? WPC_RESP_OKAY : WPC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // protection enable and override; override wins if both bits are set
    always_ff @(posedge aclk) begin
        if (!aresetn || init_s2_r) begin
            prot_on_r <= 1'b0;
        end else if (cmd_wr && cmd_byte[WPC_CMD_P_OFF]) begin
            prot_on_r <= 1'b0;
        end else if (cmd_wr && cmd_byte[WPC_CMD_P_ON]) begin
            prot_on_r <= 1'b1;
        end
    end

    // interrupt arming; interrupt_disallow_cmd wins so a stray request cannot queue
    always_ff @(posedge aclk) begin
        if (!aresetn || init_s2_r) begin
            armed_r <= 1'b0;
        end else if (cmd_wr && cmd_byte[WPC_CMD_INTERRUPT_DISALLOW_CMD]) begin
            armed_r <= 1'b0;
        end else if (cmd_wr && cmd_byte[WPC_CMD_ARM]) begin
            armed_r <= 1'b1;
        end
    end

    // block switch; lower wins when both are set
    always_ff @(posedge aclk) begin
        if (!aresetn || init_s2_r) begin
            upper_r <= 1'b0;
        end else if (cmd_wr && cmd_byte[WPC_CMD_LOWER]) begin
            upper_r <= 1'b0;
        end else if (cmd_wr && cmd_byte[WPC_CMD_UPPER]) begin
            upper_r <= 1'b1;
        end
    end

    // protection pattern, one bit per 4KB page, byte lanes honoured
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pattern_r <= WPC_PATTERN_RST;
        end else if (pat_wr) begin
            for (int i = 0; i < 4; i++) begin
                if (w_strb_r[i]) begin
                    pattern_r[i*8 +: 8] <= w_data_r[i*8 +: 8];
                end
            end
        end
    end

    // hand the write path to the guard
    assign wr.prot_on = prot_on_r;
    assign wr.pattern = pattern_r;
    assign wr.wr_req  = mem_wr_req;
    assign wr.wr_addr = mem_wr_addr;
    assign prot_hit   = wr.blocked;

    // registered memory write enable; a blocked write never reaches memory
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_wr_en       <= 1'b0;
            mem_wr_addr_out <= 17'h0_0000;
        end else begin
            mem_wr_en       <= mem_wr_req && !prot_hit;
            mem_wr_addr_out <= mem_wr_addr;
        end
    end

    // protected-write flag: a command or acknowledge clears, but a hit in
    // the same cycle wins so no attempt is lost
    assign pwf_clear = cmd_wr || ack_wr;
    always_ff @(posedge aclk) begin
        if (!aresetn || init_s2_r) begin
            protected_write_flag_r <= 1'b0;
        end else if (prot_hit) begin
            protected_write_flag_r <= 1'b1;
        end else if (pwf_clear) begin
            protected_write_flag_r <= 1'b0;
        end
    end

    // sticky interrupt status, queued only while armed; write one clears
    always_ff @(posedge aclk) begin
        if (!aresetn || init_s2_r) begin
            irq_st_r <= 1'b0;
        end else if (prot_hit && armed_r) begin
            irq_st_r <= 1'b1;
        end else if ((stclr_wr && w_data_r[WPC_IRQ_FLAG]) || ack_wr) begin
            irq_st_r <= 1'b0;
        end else if (cmd_wr && cmd_byte[WPC_CMD_INTERRUPT_DISALLOW_CMD]) begin
            irq_st_r <= 1'b0;
        end
    end

    // interrupt mask
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_msk_r <= 1'b0;
        end else if (msk_wr) begin
            irq_msk_r <= w_data_r[WPC_IRQ_FLAG];
        end
    end

    // registered outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq                <= 1'b0;
            upper_block_select <= 1'b0;
        end else begin
            irq                <= irq_st_r && irq_msk_r;
            upper_block_select <= upper_r;
        end
    end

    // status byte assembled from live state
    always_comb begin
        status_byte               = 8'h00;
        status_byte[WPC_ST_BLOCK]   = upper_r;
        status_byte[WPC_ST_PROT_ON] = prot_on_r;
        status_byte[WPC_ST_FLAG]    = protected_write_flag_r;
        status_byte[WPC_ST_EXAM]    = protected_write_flag_r;
    end

    // read channel: one outstanding read, answer one cycle after the arvalid and arready handshake
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= WPC_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= addr_mapped(s_axi_araddr) ? WPC_RESP_OKAY : WPC_RESP_SLVERR;
            unique case (s_axi_araddr)
                WPC_OFF_STATUS:  s_axi_rdata <= {24'h00_0000, status_byte};
                WPC_OFF_IRQ_ST:  s_axi_rdata <= {31'h0000_0000, irq_st_r};
                WPC_OFF_IRQ_MSK: s_axi_rdata <= {31'h0000_0000, irq_msk_r};
                WPC_OFF_PATTERN: s_axi_rdata <= pattern_r;
                default:         s_axi_rdata <= 32'h0000_0000; // command is write only
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : wpc_top
